// ===== hw/cbfpa_host.sv
// Host controller: block fill, phase centering and alarm handling over the microport
//
// Contract
// - Mode one: no centering or unstable clocks while writing transmit memory.
// - Mode two: no centering or unstable clocks while writing receive memory.
// - With doubtful clocks, program memories in modes free of correction.
// - Watch alarms during memory writes and verify suspect locations afterwards.
// - Before receive fill, set serial rate, direction and memory select.
// - After two frames check enable low; else write it low to end fill.
// - Filling both memories runs the whole sequence once per memory.
// - No centering during fill; repeat fill if a framing alarm rises.
// - At power-up program mode, general purpose and timing registers.
// - Set centering only with stable clocks; no memory writes meanwhile.
// - Any write to the alarm register clears alarms and interrupt.
`timescale 1ns/100ps
module cbfpa_host
   import cbfpa_pkg::*;
#(
   parameter int FILL_WAIT_CYC   = FILL_WAIT_CYC_DEF,
   parameter int CENTER_WAIT_CYC = CENTER_WAIT_CYC_DEF,
   parameter int FILL_RETRIES    = 3
)(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Device microport
   output cbfpa_upi_pins_t  upi_pins,
   input  wire logic [7:0]  upi_ad_i,
   input  wire logic        upi_dta_n,
   // Status
   output logic             busy
);

   typedef enum logic [4:0] {
      S_IDLE     = 5'h00,
      S_INIT_IMS = 5'h01,
      S_INIT_TIM = 5'h02,
      S_INIT_GPM = 5'h03,
      S_INIT_CLR = 5'h04,
      S_F_IMS    = 5'h05,
      S_F_SEL    = 5'h06,
      S_F_GO     = 5'h07,
      S_F_WAIT   = 5'h08,
      S_F_CHK    = 5'h09,
      S_F_ABORT  = 5'h0a,
      S_F_ALS    = 5'h0b,
      S_F_CLR    = 5'h0c,
      S_C_SET    = 5'h0d,
      S_C_WAIT   = 5'h0e,
      S_C_CHK    = 5'h0f,
      S_C_ABORT  = 5'h10,
      S_CLR      = 5'h11,
      S_RAW      = 5'h12,
      S_RAW_ALS  = 5'h13
   } cbfpa_hst_t;

   typedef struct packed {
      cbfpa_hst_t       st;
      logic             issued;
      logic [CNT_W-1:0] cnt;
      logic [3:0]       tries;
      logic [31:0]      cfg;
      logic [31:0]      fill;
      logic [31:0]      raw;
      logic [7:0]       rd_data;
      logic [7:0]       alarm_status_register;
      logic             init_done;
      logic             fill_done;
      logic             clk_missing;
      logic             retry_fail;
      logic             center_fail;
      logic             suspect;
      logic             refused;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
   } cbfpa_hstate_t;

   cbfpa_hstate_t  s_r;
   cbfpa_hstate_t  s_nxt;
   cbfpa_upi_req_t op;
   logic           upi_valid;
   logic           upi_ready;
   logic           upi_done;
   logic [7:0]     upi_rdata;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return r;
   endfunction : merge

   cbfpa_upi u_upi (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .req_valid (upi_valid),
      .req       (op),
      .req_ready (upi_ready),
      .done      (upi_done),
      .rdata     (upi_rdata),
      .pins      (upi_pins),
      .ad_i      (upi_ad_i),
      .dta_n     (upi_dta_n)
   );

   logic [7:0] ims_v;
   logic [7:0] tim_v;
   logic [7:0] gpm_v;
   logic [7:0] mask_v;
   logic [1:0] mode_v;
   logic       alarm_hit;
   logic [7:0] gpm_fill;
   logic [7:0] gpm_plain;
   logic [7:0] gpm_center;
   logic       wr_take;
   logic       rd_take;
   logic [4:0] cmd;

   always_comb begin
      ims_v  = s_r.cfg[7:0];
      tim_v  = s_r.cfg[15:8];
      gpm_v  = s_r.cfg[23:16];
      mask_v = s_r.cfg[31:24];
      mode_v = tim_v[TIM_MODE_LSB +: 2];
      // Alarms that spoil a fill or a memory write in the current mode
      alarm_hit = upi_rdata[ALS_FRAMING_CHG]
                | ((mode_v == TIM_MODE_TWO) & upi_rdata[ALS_RX_ALARM])
                | ((mode_v == TIM_MODE_ONE) & upi_rdata[ALS_TX_ALARM]);
      gpm_plain                   = gpm_v;
      gpm_plain[GPM_FILL_EN_BIT]  = 1'b0;
      gpm_plain[GPM_CENTER_BIT]   = 1'b0;
      gpm_fill                    = gpm_plain;
      gpm_fill[GPM_VAL_LSB +: 4]  = s_r.fill[3:0];
      gpm_fill[GPM_FILL_EN_BIT]   = 1'b1;
      gpm_center                  = gpm_plain;
      gpm_center[GPM_CENTER_BIT]  = 1'b1;
   end

   always_comb begin
      s_nxt   = s_r;
      op      = '0;
      busy    = (s_r.st != S_IDLE);
      wr_take = awvalid && wvalid && !s_r.bvalid;
      rd_take = arvalid && !s_r.rvalid;
      cmd     = 5'h00;

      // AXI write channel: address and data taken together
      if (s_r.bvalid && bready) s_nxt.bvalid = 1'b0;
      if (wr_take) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = RESP_OKAY;
         unique case (awaddr)
            A_CMD:    if (wstrb[0]) cmd = wdata[4:0];
            A_CFG:    s_nxt.cfg  = merge(s_r.cfg, wdata, wstrb);
            A_FILL:   s_nxt.fill = merge(s_r.fill, wdata, wstrb);
            A_RAW:    s_nxt.raw  = merge(s_r.raw, wdata, wstrb);
            A_STATUS: ;
            default:  s_nxt.bresp = RESP_SLVERR;
         endcase
      end

      // AXI read channel
      if (s_r.rvalid && rready) s_nxt.rvalid = 1'b0;
      if (rd_take) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = RESP_OKAY;
         s_nxt.rdata  = 32'h0000_0000;
         unique case (araddr)
            A_CMD:    s_nxt.rdata = 32'h0000_0000;
            A_CFG:    s_nxt.rdata = s_r.cfg;
            A_FILL:   s_nxt.rdata = {26'h000_0000, s_r.fill[5:0]};
            A_RAW:    s_nxt.rdata = {s_r.rd_data, 7'h00, s_r.raw[16:0]};
            A_STATUS: s_nxt.rdata = {8'h00, s_r.alarm_status_register, s_r.rd_data, s_r.refused,
                                     s_r.suspect, s_r.center_fail, s_r.retry_fail,
                                     s_r.clk_missing, s_r.fill_done, s_r.init_done, busy};
            default:  s_nxt.rresp = RESP_SLVERR;
         endcase
      end

      // Commands start only from idle, so centering never overlaps a fill
      if (cmd != 5'h00) begin
         if (s_r.st != S_IDLE) begin
            s_nxt.refused = 1'b1;
         end else begin
            s_nxt.refused     = 1'b0;
            s_nxt.fill_done   = 1'b0;
            s_nxt.clk_missing = 1'b0;
            s_nxt.retry_fail  = 1'b0;
            s_nxt.center_fail = 1'b0;
            s_nxt.suspect     = 1'b0;
            s_nxt.tries       = 4'h0;
            s_nxt.issued      = 1'b0;
            if (cmd[CMD_INIT])        s_nxt.st = S_INIT_IMS;
            else if (cmd[CMD_FILL])   s_nxt.st = S_F_IMS;
            else if (cmd[CMD_CENTER]) s_nxt.st = S_C_SET;
            else if (cmd[CMD_CLR])    s_nxt.st = S_CLR;
            else                      s_nxt.st = S_RAW;
         end
      end

      unique case (s_r.st)
         S_IDLE: ;
         S_INIT_IMS: begin
            op = '{1'b1, DEV_IMS, ims_v};
            if (upi_done) s_nxt.st = S_INIT_TIM;
         end
         S_INIT_TIM: begin
            op = '{1'b1, DEV_TIM, tim_v};
            if (upi_done) s_nxt.st = S_INIT_GPM;
         end
         S_INIT_GPM: begin
            op = '{1'b1, DEV_GPM, gpm_plain};
            if (upi_done) s_nxt.st = S_INIT_CLR;
         end
         S_INIT_CLR: begin
            op = '{1'b1, DEV_ALS, mask_v};
            if (upi_done) begin
               s_nxt.init_done = 1'b1;
               s_nxt.st        = S_IDLE;
            end
         end
         S_F_IMS: begin
            op = '{1'b1, DEV_IMS, ims_v};
            if (upi_done) s_nxt.st = S_F_SEL;
         end
         S_F_SEL: begin
            op = '{1'b1, DEV_CTRL, 8'h00};
            op.data[CTRL_SEL_LSB +: 3] = s_r.fill[FILL_RX_BIT] ? SEL_RX_HIGH : SEL_TX_HIGH;
            if (upi_done) s_nxt.st = S_F_GO;
         end
         S_F_GO: begin
            op = '{1'b1, DEV_GPM, gpm_fill};
            if (upi_done) begin
               s_nxt.cnt = CNT_W'(FILL_WAIT_CYC - 1);
               s_nxt.st  = S_F_WAIT;
            end
         end
         S_F_WAIT: begin
            // Two frames cover the whole high block on the path's clocks
            if (s_r.cnt == '0) s_nxt.st = S_F_CHK;
            else s_nxt.cnt = s_r.cnt - 1'b1;
         end
         S_F_CHK: begin
            op = '{1'b0, DEV_GPM, 8'h00};
            if (upi_done) begin
               s_nxt.rd_data = upi_rdata;
               if (upi_rdata[GPM_FILL_EN_BIT]) begin
                  s_nxt.clk_missing = 1'b1;
                  s_nxt.st          = S_F_ABORT;
               end else begin
                  s_nxt.st = S_F_ALS;
               end
            end
         end
         S_F_ABORT: begin
            op = '{1'b1, DEV_GPM, gpm_plain};
            if (upi_done) s_nxt.st = S_IDLE;
         end
         S_F_ALS: begin
            op = '{1'b0, DEV_ALS, 8'h00};
            if (upi_done) begin
               s_nxt.alarm_status_register = upi_rdata;
               if (alarm_hit) begin
                  s_nxt.st = S_F_CLR;
               end else if (s_r.fill[FILL_BOTH_BIT] && !s_r.fill[FILL_RX_BIT]) begin
                  s_nxt.fill[FILL_RX_BIT] = 1'b1;
                  s_nxt.tries             = 4'h0;
                  s_nxt.st                = S_F_IMS;
               end else begin
                  s_nxt.fill_done = 1'b1;
                  s_nxt.st        = S_IDLE;
               end
            end
         end
         S_F_CLR: begin
            op = '{1'b1, DEV_ALS, mask_v};
            if (upi_done) begin
               if (s_r.tries == 4'(FILL_RETRIES - 1)) begin
                  s_nxt.retry_fail = 1'b1;
                  s_nxt.st         = S_IDLE;
               end else begin
                  s_nxt.tries = s_r.tries + 4'h1;
                  s_nxt.st    = S_F_SEL;
               end
            end
         end
         S_C_SET: begin
            op = '{1'b1, DEV_GPM, gpm_center};
            if (upi_done) begin
               s_nxt.cnt = CNT_W'(CENTER_WAIT_CYC - 1);
               s_nxt.st  = S_C_WAIT;
            end
         end
         S_C_WAIT: begin
            // Memory writes are held off while centering runs
            if (s_r.cnt == '0) s_nxt.st = S_C_CHK;
            else s_nxt.cnt = s_r.cnt - 1'b1;
         end
         S_C_CHK: begin
            op = '{1'b0, DEV_GPM, 8'h00};
            if (upi_done) begin
               s_nxt.rd_data = upi_rdata;
               if (upi_rdata[GPM_CENTER_BIT]) begin
                  s_nxt.center_fail = 1'b1;
                  s_nxt.st          = S_C_ABORT;
               end else begin
                  s_nxt.st = S_IDLE;
               end
            end
         end
         S_C_ABORT: begin
            op = '{1'b1, DEV_GPM, gpm_plain};
            if (upi_done) s_nxt.st = S_IDLE;
         end
         S_CLR: begin
            op = '{1'b1, DEV_ALS, mask_v};
            if (upi_done) s_nxt.st = S_IDLE;
         end
         S_RAW: begin
            op = '{s_r.raw[RAW_WR_BIT], s_r.raw[7:0], s_r.raw[15:8]};
            if (upi_done) begin
               s_nxt.rd_data = upi_rdata;
               if (s_r.raw[RAW_WR_BIT] && s_r.raw[DEV_MEM_BIT]) s_nxt.st = S_RAW_ALS;
               else s_nxt.st = S_IDLE;
            end
         end
         S_RAW_ALS: begin
            op = '{1'b0, DEV_ALS, 8'h00};
            if (upi_done) begin
               s_nxt.alarm_status_register = upi_rdata;
               if (alarm_hit) s_nxt.suspect = 1'b1;
               s_nxt.st = S_IDLE;
            end
         end
         default: s_nxt.st = S_IDLE;
      endcase

      // One microport request per bus state
      upi_valid = (s_r.st != S_IDLE) && (s_r.st != S_F_WAIT)
                && (s_r.st != S_C_WAIT) && !s_r.issued;
      if (upi_valid && upi_ready) s_nxt.issued = 1'b1;
      if (upi_done) s_nxt.issued = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r    <= '0;
         s_r.st <= S_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign awready = wr_take;
   assign wready  = wr_take;
   assign bvalid  = s_r.bvalid;
   assign bresp   = s_r.bresp;
   assign arready = rd_take;
   assign rvalid  = s_r.rvalid;
   assign rdata   = s_r.rdata;
   assign rresp   = s_r.rresp;

endmodule : cbfpa_host

// ===== hw/cbfpa_pkg.sv
// Shared constants and carrier types for the connection-memory host controller
package cbfpa_pkg;

   // Timing
   localparam int CLK_NS               = 8;
   localparam int FRAME_NS             = 125000;
   localparam int FILL_FRAMES          = 2;
   localparam int CENTER_FRAMES        = 8;
   localparam int CENTER_MARGIN_FRAMES = 1;
   localparam int FILL_WAIT_CYC_DEF    = FILL_FRAMES * FRAME_NS / CLK_NS;
   localparam int CENTER_WAIT_CYC_DEF  =
      (CENTER_FRAMES + CENTER_MARGIN_FRAMES) * FRAME_NS / CLK_NS;
   localparam int CNT_W                = 20;

   // Device register addresses (address bit 7 low selects registers)
   localparam logic [7:0] DEV_IMS  = 8'h00;
   localparam logic [7:0] DEV_CTRL = 8'h01;
   localparam logic [7:0] DEV_TIM  = 8'h02;
   localparam logic [7:0] DEV_GPM  = 8'h03;
   localparam logic [7:0] DEV_ALS  = 8'h04;
   localparam int         DEV_MEM_BIT = 7;

   // Device register fields
   localparam int         GPM_FILL_EN_BIT  = 0;
   localparam int         GPM_CENTER_BIT   = 1;
   localparam int         GPM_VAL_LSB      = 4;
   localparam int         CTRL_SEL_LSB     = 0;
   localparam logic [2:0] SEL_TX_HIGH      = 3'h1;
   localparam logic [2:0] SEL_RX_HIGH      = 3'h3;
   localparam int         ALS_FRAMING_CHG  = 0;
   localparam int         ALS_RX_ALARM     = 1;
   localparam int         ALS_TX_ALARM     = 2;
   localparam int         TIM_MODE_LSB     = 0;
   localparam int         TIM_INTERNAL_CLOCK_SELECT_BIT   = 2;
   localparam logic [1:0] TIM_MODE_ONE     = 2'h0;
   localparam logic [1:0] TIM_MODE_TWO     = 2'h1;

   // Own AXI register offsets
   localparam logic [7:0] A_CMD    = 8'h00;
   localparam logic [7:0] A_CFG    = 8'h04;
   localparam logic [7:0] A_FILL   = 8'h08;
   localparam logic [7:0] A_RAW    = 8'h0c;
   localparam logic [7:0] A_STATUS = 8'h10;

   // Command bits
   localparam int CMD_INIT   = 0;
   localparam int CMD_FILL   = 1;
   localparam int CMD_CENTER = 2;
   localparam int CMD_CLR    = 3;
   localparam int CMD_RAW    = 4;

   // Field positions in own registers
   localparam int FILL_RX_BIT   = 4;
   localparam int FILL_BOTH_BIT = 5;
   localparam int RAW_WR_BIT    = 16;

   // Microport strobe timing in clock cycles
   localparam logic [3:0] UPI_ALE_CYC  = 4'h2;
   localparam logic [3:0] UPI_HOLD_CYC = 4'h1;
   localparam logic [3:0] UPI_REC_CYC  = 4'h2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       write;
      logic [7:0] addr;
      logic [7:0] data;
   } cbfpa_upi_req_t;

   typedef struct packed {
      logic [7:0] ad_o;
      logic       ad_oe;
      logic       ale;
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
   } cbfpa_upi_pins_t;

endpackage : cbfpa_pkg

// ===== hw/cbfpa_upi.sv
// Multiplexed microport bus-cycle engine toward the switch device
`timescale 1ns/100ps
module cbfpa_upi
   import cbfpa_pkg::*;
(
   // Clock and reset
   input  wire logic            aclk,
   input  wire logic            aresetn,
   // Request side
   input  wire logic            req_valid,
   input  wire cbfpa_upi_req_t  req,
   output logic                 req_ready,
   output logic                 done,
   output logic [7:0]           rdata,
   // Device pins
   output cbfpa_upi_pins_t      pins,
   input  wire logic [7:0]      ad_i,
   input  wire logic            dta_n
);

   typedef enum logic [2:0] {
      U_IDLE = 3'h0,
      U_ADDR = 3'h1,
      U_HOLD = 3'h2,
      U_STRB = 3'h3,
      U_REC  = 3'h4
   } cbfpa_ust_t;

   typedef struct packed {
      cbfpa_ust_t      st;
      logic [3:0]      cnt;
      cbfpa_upi_req_t  req;
      cbfpa_upi_pins_t pins;
      logic [7:0]      rdata;
      logic            done;
      logic            dta_s1;
      logic            dta_s2;
      logic [7:0]      ad_s1;
      logic [7:0]      ad_s2;
   } cbfpa_ustate_t;

   cbfpa_ustate_t s_r;
   cbfpa_ustate_t s_nxt;

   always_comb begin
      s_nxt        = s_r;
      s_nxt.done   = 1'b0;
      s_nxt.dta_s1 = dta_n;
      s_nxt.dta_s2 = s_r.dta_s1;
      s_nxt.ad_s1  = ad_i;
      s_nxt.ad_s2  = s_r.ad_s1;
      unique case (s_r.st)
         U_IDLE: begin
            if (req_valid) begin
               s_nxt.req        = req;
               s_nxt.pins.ad_o  = req.addr;
               s_nxt.pins.ad_oe = 1'b1;
               s_nxt.pins.ale   = 1'b1;
               s_nxt.cnt        = UPI_ALE_CYC - 4'h1;
               s_nxt.st         = U_ADDR;
            end
         end
         U_ADDR: begin
            if (s_r.cnt == 4'h0) begin
               s_nxt.pins.ale = 1'b0;
               s_nxt.cnt      = UPI_HOLD_CYC - 4'h1;
               s_nxt.st       = U_HOLD;
            end else begin
               s_nxt.cnt = s_r.cnt - 4'h1;
            end
         end
         U_HOLD: begin
            if (s_r.cnt == 4'h0) begin
               s_nxt.pins.cs_n  = 1'b0;
               s_nxt.pins.wr_n  = ~s_r.req.write;
               s_nxt.pins.rd_n  = s_r.req.write;
               s_nxt.pins.ad_o  = s_r.req.data;
               s_nxt.pins.ad_oe = s_r.req.write;
               s_nxt.st         = U_STRB;
            end else begin
               s_nxt.cnt = s_r.cnt - 4'h1;
            end
         end
         U_STRB: begin
            // No timeout: a missing device clock stalls here by design
            if (!s_r.dta_s2) begin
               s_nxt.rdata     = s_r.ad_s2;
               s_nxt.pins.cs_n = 1'b1;
               s_nxt.pins.rd_n = 1'b1;
               s_nxt.pins.wr_n = 1'b1;
               s_nxt.cnt       = UPI_REC_CYC - 4'h1;
               s_nxt.st        = U_REC;
            end
         end
         U_REC: begin
            if (s_r.cnt == 4'h0) begin
               s_nxt.pins.ad_oe = 1'b0;
               s_nxt.done       = 1'b1;
               s_nxt.st         = U_IDLE;
            end else begin
               s_nxt.cnt = s_r.cnt - 4'h1;
            end
         end
         default: s_nxt.st = U_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r           <= '0;
         s_r.st        <= U_IDLE;
         s_r.pins.cs_n <= 1'b1;
         s_r.pins.rd_n <= 1'b1;
         s_r.pins.wr_n <= 1'b1;
         s_r.dta_s1    <= 1'b1;
         s_r.dta_s2    <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign req_ready = (s_r.st == U_IDLE);
   assign done      = s_r.done;
   assign rdata     = s_r.rdata;
   assign pins      = s_r.pins;

endmodule : cbfpa_upi

// ===== test/cbfpa_dev_model.sv
// Behavioural switch device seen through its microport
`timescale 1ns/100ps
module cbfpa_dev_model
   import cbfpa_pkg::*;
#(
   parameter int CLR_CYC = 10
)(
   input  wire logic            aclk,
   input  wire cbfpa_upi_pins_t pins,
   input  wire logic            clk_ok,
   input  wire logic            inj,
   output logic [7:0]           ad_i,
   output logic                 dta_n
);
   logic [7:0] regs [8] = '{default: 8'h00};
   logic [7:0] a = 8'h00, lastv = 8'h00;
   logic [3:0] fill_val = 4'h0;
   logic [2:0] fill_sel = 3'h0;
   logic       drv = 1'h0;
   int         acc = 0, cnt = 0;
   initial dta_n = 1'h1;
   // Released bus shows the inverted last value
   assign ad_i = pins.ad_oe ? pins.ad_o : drv ? regs[a[2:0]] : ~lastv;
   always @(posedge aclk) begin
      lastv <= ad_i;
      drv <= !pins.cs_n && !pins.rd_n;
      acc <= (!pins.cs_n && !(pins.rd_n && pins.wr_n)) ? acc + 1 : 0;
      dta_n <= acc < 2;
      if (pins.ale)
         a <= pins.ad_o;
      if (acc == 2 && !pins.wr_n && !a[DEV_MEM_BIT]) begin
         regs[a[2:0]] <= (a == DEV_ALS) ? 8'h00 : pins.ad_o;
         if (a == DEV_GPM && pins.ad_o[GPM_FILL_EN_BIT]) begin
            fill_val <= pins.ad_o[7:4];
            fill_sel <= regs[1][2:0];
            // Lock loss flags the mode's own alarm beside the framing change
            if (inj)
               regs[4] <= {5'h00, regs[2][1:0] == TIM_MODE_ONE,
                           regs[2][1:0] == TIM_MODE_TWO, 1'h1};
         end
         cnt <= CLR_CYC;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         // Without clock the enable and centering bits stay up
         if (cnt == 1 && clk_ok)
            regs[3][1:0] <= 2'h0;
      end
   end
endmodule : cbfpa_dev_model

// ===== test/cbfpa_host_properties.sv
// Port assertions for the host controller
`timescale 1ns/100ps
module cbfpa_host_chk
   import cbfpa_pkg::*;
(
   // Clock, reset and bus handshakes
   input wire logic            aclk, aresetn, awvalid, wvalid, awready, bvalid, bready,
   input wire logic            arvalid, arready, rvalid, rready,
   // Microport
   input wire cbfpa_upi_pins_t upi_pins
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_latch;
      upi_pins.ale [*2] ##1 !upi_pins.ale ##1 !upi_pins.cs_n;
   endsequence
   chk_wr_ans: assert property (awvalid && wvalid && awready |=> bvalid)
      else $error("write not answered");
   chk_wr_block: assert property (bvalid |-> !awready)
      else $error("write taken while answering");
   chk_b_drop: assert property (bvalid && bready |=> !bvalid)
      else $error("write answer held");
   chk_rd_ans: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   chk_r_drop: assert property (rvalid && rready |=> !rvalid)
      else $error("read answer held");
   chk_ale_seq: assert property ($rose(upi_pins.ale) |-> s_latch)
      else $error("latch phase wrong");
   chk_wr_drive: assert property (!upi_pins.wr_n |-> upi_pins.ad_oe && upi_pins.rd_n)
      else $error("write strobe without data");
   chk_rd_float: assert property (!upi_pins.rd_n |-> !upi_pins.ad_oe)
      else $error("bus driven during read");
   chk_cs_gap: assert property ($rose(upi_pins.cs_n) |=> upi_pins.cs_n [*4])
      else $error("strobes too close");
endmodule : cbfpa_host_chk

bind cbfpa_host cbfpa_host_chk i_chk (.aclk, .aresetn, .awvalid, .wvalid, .awready, .bvalid,
   .bready, .arvalid, .arready, .rvalid, .rready, .upi_pins);

// ===== test/cbfpa_host_test.sv
// Self-checking bench for the host controller
`timescale 1ns/100ps
module cbfpa_host_test;
   import cbfpa_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, clk_ok = 1, inj = 0, awready, wready, bvalid;
   logic arready, rvalid, busy, dta_n;
   logic [3:0] wstrb = 4'hf;
   logic [7:0] awaddr = 0, araddr = 0, ad_i;
   logic [31:0] wdata = 0, rdata, s = 25, cfg, v, f;
   logic [1:0] bresp, rresp, r;
   cbfpa_upi_pins_t pins;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   always #4 aclk = ~aclk;
   cbfpa_host #(.FILL_WAIT_CYC(20), .CENTER_WAIT_CYC(20)) i_dut (.aclk, .aresetn, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .upi_pins(pins),
      .upi_ad_i(ad_i), .upi_dta_n(dta_n), .busy);
   cbfpa_dev_model i_dev (.aclk, .pins, .clk_ok, .inj, .ad_i, .dta_n);
   function automatic logic [31:0] xs();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [7:0] exp_st(int c);
      // Init done stays set once the first init has run
      if (c == 1 || c == 8)
         return 8'h02;
      if (c == 16)
         return inj ? 8'h42 : 8'h02;
      if (c == 2)
         return !clk_ok ? 8'h0a : inj ? 8'h12 : 8'h06;
      return clk_ok ? 8'h02 : 8'h22;
   endfunction : exp_st
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   task automatic cmp(input string n, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic axw(input logic [7:0] ad, input logic [31:0] d);
      awaddr <= ad;
      wdata <= d;
      awvalid <= '1;
      wvalid <= '1;
      bready <= '1;
      do @(posedge aclk); while (awready !== 1'h1);
      awvalid <= '0;
      wvalid <= '0;
      do @(posedge aclk); while (bvalid !== 1'h1);
      r = bresp;
      bready <= '0;
      @(posedge aclk);
   endtask : axw
   task automatic axr(input logic [7:0] ad);
      araddr <= ad;
      arvalid <= '1;
      rready <= '1;
      do @(posedge aclk); while (arready !== 1'h1);
      arvalid <= '0;
      do @(posedge aclk); while (rvalid !== 1'h1);
      v = rdata;
      r = rresp;
      rready <= '0;
      @(posedge aclk);
   endtask : axr
   task automatic run(input int c);
      axw(A_CMD, c);
      repeat (2) @(posedge aclk);
      while (busy !== 1'h0) @(posedge aclk);
      axr(A_STATUS);
      cmp("status", exp_st(c), v[7:0]);
      $display("test cmd %0d done", c);
   endtask : run
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= '1;
      @(posedge aclk);
      axr(A_STATUS);
      cmp("reset status", 0, v);
      axr(8'h40);
      cmp("bad rd resp", RESP_SLVERR, r);
      axw(8'h40, 32'h1);
      cmp("bad wr resp", RESP_SLVERR, r);
      cfg = xs();
      axw(A_CFG, cfg);
      axr(A_CFG);
      cmp("cfg", cfg, v);
      wstrb <= 4'h5;
      axw(A_CFG, ~cfg);
      wstrb <= 4'hf;
      cfg ^= 32'h00ff_00ff;
      axr(A_CFG);
      cmp("cfg strb", cfg, v);
      run(1);
      cmp("ims", cfg[7:0], i_dev.regs[0]);
      cmp("tim", cfg[15:8], i_dev.regs[2]);
      cmp("gpm", cfg[23:16] & 8'hfc, i_dev.regs[3]);
      cmp("als", 0, i_dev.regs[4]);
      for (int k = 0; k < 3; k++) begin
         {clk_ok, inj} <= k == 0 ? 2'h3 : k == 1 ? 2'h0 : 2'h2;
         f = xs() & 32'hf;
         axw(A_FILL, f);
         run(2);
         cmp("fill en", 0, i_dev.regs[3][0]);
      end
      cmp("fill val", f, i_dev.fill_val);
      cmp("fill sel", SEL_TX_HIGH, i_dev.fill_sel);
      axw(A_FILL, f | 32'h20);
      run(2);
      cmp("both sel", SEL_RX_HIGH, i_dev.fill_sel);
      axr(A_FILL);
      cmp("fill rb", f | 32'h30, v);
      for (int k = 0; k < 2; k++) begin
         clk_ok <= k[0];
         run(4);
         cmp("center", 0, i_dev.regs[3][1]);
      end
      {clk_ok, inj} <= 2'h1;
      run(2);
      axw(A_RAW, 32'h1_0080 | (xs() & 32'hff00));
      run(16);
      run(8);
      cmp("als clr", 0, i_dev.regs[4]);
      {clk_ok, inj} <= 2'h2;
      axw(A_CMD, 32'h2);
      axw(A_CMD, 32'h1);
      while (busy !== 1'h0) @(posedge aclk);
      axr(A_STATUS);
      cmp("refused", 8'h86, v[7:0]);
      summarize();
   end
endmodule : cbfpa_host_test
